// ===== hw/tcq_pkg.sv
/*
 * tcq_pkg: register map, field layout, reset values and element sizing for the
 * transmit buffer FIFO / queue manager.
 * assumes: one 32-bit AHB-Lite slave port, 32 transmit buffers.
 */
package tcq_pkg;

   // ********************************************************************
   // buffer geometry
   // ********************************************************************
   localparam int          NUM_BUF      = 32;
   localparam int          IDX_W        = 5;
   localparam int          LVL_W        = 6;
   localparam int          ID_W         = 29;
   localparam int          ADDR_W       = 16;

   // ********************************************************************
   // register byte offsets
   // ********************************************************************
   localparam logic [7:0]  OFS_TX_BUF_CFG   = 8'h00;
   localparam logic [7:0]  OFS_TX_ELEM_CFG  = 8'h04;
   localparam logic [7:0]  OFS_TX_FQ_STATUS = 8'h08;
   localparam logic [7:0]  OFS_TX_ADD_REQ   = 8'h0C;
   localparam logic [7:0]  OFS_TX_CANCEL    = 8'h10;
   localparam logic [7:0]  OFS_NEXT_ADDR    = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h18;
   localparam logic [7:0]  OFS_IRQ_MASK     = 8'h1C;

   // ********************************************************************
   // field positions
   // ********************************************************************
   localparam int          POS_START_ADDR   = 0;
   localparam int          POS_QUEUE_SEL    = 30;
   localparam int          POS_DFS          = 0;
   localparam int          POS_ELEM_WORDS   = 8;
   localparam int          POS_ELEM_BYTES   = 16;
   localparam int          POS_FREE_LVL     = 0;
   localparam int          POS_GET_IDX      = 8;
   localparam int          POS_PUT_IDX      = 16;
   localparam int          POS_FULL         = 21;
   localparam int          IRQ_W            = 3;
   localparam int          IRQ_TX_DONE      = 0;
   localparam int          IRQ_CANCEL       = 1;
   localparam int          IRQ_FULL         = 2;

   // ********************************************************************
   // reset values
   // ********************************************************************
   localparam logic [ADDR_W-1:0] RST_START_ADDR = 16'h0000;
   localparam logic              RST_QUEUE_SEL  = 1'b0;
   localparam logic [2:0]        RST_DFS        = 3'h0;
   localparam logic [IRQ_W-1:0]  RST_IRQ_MASK   = 3'h0;
   localparam logic [31:0]       READ_ZERO      = 32'h0000_0000;

   typedef enum logic [1:0] {
      TCQ_HTRANS_IDLE   = 2'b00,
      TCQ_HTRANS_BUSY   = 2'b01,
      TCQ_HTRANS_NONSEQ = 2'b10,
      TCQ_HTRANS_SEQ    = 2'b11
   } tcq_htrans_t;

   // element size in 32-bit words per data field size code
   function automatic logic [4:0] tcq_elem_words(input logic [2:0] code);
      case (code)
         3'b000:  tcq_elem_words = 5'h04;
         3'b001:  tcq_elem_words = 5'h05;
         3'b010:  tcq_elem_words = 5'h06;
         3'b011:  tcq_elem_words = 5'h07;
         3'b100:  tcq_elem_words = 5'h08;
         3'b101:  tcq_elem_words = 5'h0A;
         3'b110:  tcq_elem_words = 5'h0E;
         default: tcq_elem_words = 5'h12;
      endcase
   endfunction : tcq_elem_words

   // data field length in bytes per data field size code
   function automatic logic [6:0] tcq_elem_bytes(input logic [2:0] code);
      case (code)
         3'b000:  tcq_elem_bytes = 7'h08;
         3'b001:  tcq_elem_bytes = 7'h0C;
         3'b010:  tcq_elem_bytes = 7'h10;
         3'b011:  tcq_elem_bytes = 7'h14;
         3'b100:  tcq_elem_bytes = 7'h18;
         3'b101:  tcq_elem_bytes = 7'h20;
         3'b110:  tcq_elem_bytes = 7'h30;
         default: tcq_elem_bytes = 7'h40;
      endcase
   endfunction : tcq_elem_bytes

endpackage : tcq_pkg

// ===== hw/tcq_pick.sv
/*
 * tcq_pick: combinational priority picker for queue mode.
 * assumes: ids are flattened, buffer i at bits [i*ID_W +: ID_W].
 */
`timescale 1ns/10ps
module tcq_pick
   import tcq_pkg::*;
(
   input  wire logic [NUM_BUF-1:0]      pending,
   input  wire logic [NUM_BUF*ID_W-1:0] ids,
   output logic                         found,
   output logic      [IDX_W-1:0]        bestIdx
);

   logic [ID_W-1:0] bestId;

   // strict less-than keeps the lower buffer number on equal ids
   always_comb begin
      found   = 1'b0;
      bestIdx = '0;
      bestId  = '0;
      for (int i = 0; i < NUM_BUF; i++) begin
         if (pending[i] && (!found || (ids[i*ID_W +: ID_W] < bestId))) begin // RULE13 RULE14
            found   = 1'b1;
            bestIdx = IDX_W'(i);
            bestId  = ids[i*ID_W +: ID_W];
         end
      end
   end

endmodule : tcq_pick

// ===== hw/tcq_tx_queue_mgr.sv
/*
 * tcq_tx_queue_mgr: transmit buffer FIFO / priority queue manager with AHB-Lite
 * register slave and a buffer request interface to the protocol engine.
 * assumes: engine holds txBusy while sending buffer txIdx and pulses txDone
 * once at the end; message RAM writes are snooped via idWrEn for queue ids.
 */
// Decided for this implementation: the address map and the AHB-Lite register port.
//Contract
//RULE1 - size code selects data bytes and element words, 8/4 up to 64/18
//RULE2 - select bit 0 runs FIFO, sending the buffer at the get index
//RULE3 - each FIFO transmission advances get index cyclically until empty
//RULE4 - free level equals get index minus put index, count of free elements
//RULE5 - add advances put index; put equal to get sets full flag
//RULE6 - software writes no message while full is set
//RULE7 - software fills the put element then sets its add request bit
//RULE8 - n requests at once advance put index cyclically by n
//RULE9 - software never requests more buffers than the free level
//RULE10 - cancelling get buffer moves get to next pending, level recomputed
//RULE11 - cancelling any other buffer leaves get index and level alone
//RULE12 - next free address is start plus put index times element words
//RULE13 - select bit 1 runs priority queue, lowest id sent first
//RULE14 - equal ids in queue send lowest buffer number first
//RULE15 - queue add moves put index cyclically to next free buffer
//RULE16 - FIFO sends equal ids in the order written
//RULE17 - queue fully occupied signals full and holds put index
`timescale 1ns/10ps
module tcq_tx_queue_mgr
   import tcq_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic                idWrEn,
   input  wire logic [IDX_W-1:0]    idWrIdx,
   input  wire logic [ID_W-1:0]     idWrVal,
   input  wire logic                txBusy,
   input  wire logic                txDone,
   output logic                     txReq,
   output logic      [IDX_W-1:0]    txIdx,
   output logic                     irq
);

   // ********************************************************************
   // bus slave
   // ********************************************************************
   logic [7:0]         wrAddr_q;
   logic               wrPend_q;
   logic [31:0]        rdata_q;
   logic               readyOut_q;
   logic               accept;
   logic               rdAccept;
   logic [31:0]        rdMux;

   assign accept   = hsel && hready && (htrans == TCQ_HTRANS_NONSEQ || htrans == TCQ_HTRANS_SEQ);
   assign rdAccept = accept && !hwrite;

   // zero wait states: read data is registered at the address phase edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wrAddr_q   <= 8'h00;
         wrPend_q   <= 1'b0;
         rdata_q    <= READ_ZERO;
         readyOut_q <= 1'b1;
      end else begin
         wrAddr_q   <= haddr[7:0];
         wrPend_q   <= accept && hwrite;
         rdata_q    <= rdAccept ? rdMux : READ_ZERO;
         readyOut_q <= 1'b1;
      end
   end

   assign hrdata    = rdata_q;
   assign hreadyout = readyOut_q;
   assign hresp     = 1'b0;

   logic wrBufCfg, wrElemCfg, wrAdd, wrCancel, wrMask, rdIrq;
   assign wrBufCfg  = wrPend_q && (wrAddr_q == OFS_TX_BUF_CFG);
   assign wrElemCfg = wrPend_q && (wrAddr_q == OFS_TX_ELEM_CFG);
   assign wrAdd     = wrPend_q && (wrAddr_q == OFS_TX_ADD_REQ);
   assign wrCancel  = wrPend_q && (wrAddr_q == OFS_TX_CANCEL);
   assign wrMask    = wrPend_q && (wrAddr_q == OFS_IRQ_MASK);
   assign rdIrq     = rdAccept && (haddr[7:0] == OFS_IRQ_STATUS);

   // ********************************************************************
   // configuration
   // ********************************************************************
   logic [ADDR_W-1:0]  startAddr_q;
   logic               queueSel_q;
   logic [2:0]         dfs_q;
   logic [IRQ_W-1:0]   irqMask_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         startAddr_q <= RST_START_ADDR;
         queueSel_q  <= RST_QUEUE_SEL;
         dfs_q       <= RST_DFS;
         irqMask_q   <= RST_IRQ_MASK;
      end else begin
         if (wrBufCfg) begin
            startAddr_q <= hwdata[POS_START_ADDR +: ADDR_W];
            queueSel_q  <= hwdata[POS_QUEUE_SEL];
         end
         if (wrElemCfg) begin
            dfs_q <= hwdata[POS_DFS +: 3];
         end
         if (wrMask) begin
            irqMask_q <= hwdata[IRQ_W-1:0];
         end
      end
   end

   logic [4:0]         elemWords;
   logic [6:0]         elemBytes;
   logic [ADDR_W-1:0]  nextFreeAddr;
   assign elemWords = tcq_elem_words(dfs_q);  // RULE1
   assign elemBytes = tcq_elem_bytes(dfs_q);  // RULE1

   // ********************************************************************
   // buffer state
   // ********************************************************************
   logic [NUM_BUF-1:0]      pend_q;
   logic [NUM_BUF-1:0]      pend_d;
   logic [NUM_BUF-1:0]      addBits;
   logic [NUM_BUF-1:0]      cancelBits;
   logic [NUM_BUF-1:0]      doneBits;
   logic [NUM_BUF*ID_W-1:0] idFlat;
   logic [IDX_W-1:0]        get_q;
   logic [IDX_W-1:0]        get_d;
   logic [IDX_W-1:0]        put_q;
   logic [IDX_W-1:0]        put_d;
   logic                    full_q;
   logic                    full_d;
   logic [LVL_W-1:0]        freeLvl;
   logic [LVL_W-1:0]        nAdd;
   logic                    doneValid;
   logic                    cancelAtGet;
   logic                    nextPendFound;
   logic [IDX_W-1:0]        nextPendIdx;
   logic                    nextFreeFound;
   logic [IDX_W-1:0]        nextFreeIdx;

   // adds only count buffers that were free; doneBits clears the sent buffer
   assign addBits    = wrAdd ? (hwdata & ~pend_q) : '0;
   assign cancelBits = wrCancel ? (hwdata & pend_q) : '0;
   assign doneValid  = txDone && pend_q[txIdx];
   assign doneBits   = doneValid ? (NUM_BUF'(1) << txIdx) : '0;
   assign pend_d     = (pend_q | addBits) & ~cancelBits & ~doneBits;
   assign cancelAtGet = cancelBits[get_q] && !(doneValid && txIdx == get_q); // RULE10 RULE11

   genvar gb;
   generate
      for (gb = 0; gb < NUM_BUF; gb++) begin : gBuf
         logic [ID_W-1:0] id_q;
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               pend_q[gb] <= 1'b0;
               id_q       <= '0;
            end else begin
               pend_q[gb] <= pend_d[gb];
               if (idWrEn && idWrIdx == IDX_W'(gb)) begin
                  id_q <= idWrVal;
               end
            end
         end
         assign idFlat[gb*ID_W +: ID_W] = id_q;
      end
   endgenerate

   // count of newly requested buffers and cyclic searches from an index
   function automatic logic [LVL_W-1:0] popCount(input logic [NUM_BUF-1:0] v);
      popCount = '0;
      for (int i = 0; i < NUM_BUF; i++) begin
         popCount = popCount + LVL_W'(v[i]);
      end
   endfunction : popCount

   function automatic logic [IDX_W:0] nextSet(input logic [NUM_BUF-1:0] v, input logic [IDX_W-1:0] from);
      logic [IDX_W-1:0] k;
      nextSet = '0;
      for (int i = NUM_BUF; i >= 1; i--) begin
         k = from + IDX_W'(i);
         if (v[k]) begin
            nextSet = {1'b1, k};
         end
      end
   endfunction : nextSet

   assign nAdd = popCount(addBits);
   assign {nextPendFound, nextPendIdx} = nextSet(pend_d, get_q);
   assign {nextFreeFound, nextFreeIdx} = nextSet(~pend_d, put_q);

   always_comb begin
      get_d  = get_q;
      put_d  = put_q;
      full_d = full_q;
      if (!queueSel_q) begin                                         // RULE2
         put_d = put_q + nAdd[IDX_W-1:0];                            // RULE5 RULE8
         if (doneValid && txIdx == get_q) begin
            get_d = get_q + IDX_W'(1);                               // RULE3 RULE16
         end else if (cancelAtGet) begin
            get_d = nextPendFound ? nextPendIdx : put_d;             // RULE10
         end
         full_d = (pend_d != '0) && (put_d == get_d);                // RULE5
      end else begin
         if (nAdd != '0 && nextFreeFound) begin
            put_d = nextFreeIdx;                                     // RULE15
         end
         full_d = &pend_d;                                           // RULE17
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         get_q  <= '0;
         put_q  <= '0;
         full_q <= 1'b0;
      end else begin
         get_q  <= get_d;
         put_q  <= put_d;
         full_q <= full_d;
      end
   end

   // mod-32 difference; equal indices mean empty unless the full flag is up
   assign freeLvl = full_q ? '0 : (get_q == put_q) ? LVL_W'(NUM_BUF) : LVL_W'(IDX_W'(get_q - put_q)); // RULE4
   assign nextFreeAddr = startAddr_q + ADDR_W'(put_q * elemWords);                           // RULE12

   // ********************************************************************
   // engine request
   // ********************************************************************
   logic               pickFound;
   logic [IDX_W-1:0]   pickIdx;
   logic               selValid;
   logic [IDX_W-1:0]   selIdx;
   logic               txReq_q;
   logic [IDX_W-1:0]   txIdx_q;

   tcq_pick uPick (
      .pending (pend_q),
      .ids     (idFlat),
      .found   (pickFound),
      .bestIdx (pickIdx)
   );

   assign selValid = queueSel_q ? pickFound : pend_q[get_q];        // RULE2 RULE13
   assign selIdx   = queueSel_q ? pickIdx : get_q;

   // selection is frozen while the engine is sending, so the index it
   // acknowledges with txDone is the one it started on
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txReq_q <= 1'b0;
         txIdx_q <= '0;
      end else if (!txBusy) begin
         txReq_q <= selValid && !txDone;
         txIdx_q <= selIdx;
      end
   end

   assign txReq = txReq_q;
   assign txIdx = txIdx_q;

   // ********************************************************************
   // interrupts
   // ********************************************************************
   logic [IRQ_W-1:0]   irqSt_q;
   logic [IRQ_W-1:0]   irqEv;
   logic               irq_q;

   assign irqEv = {full_d && !full_q, cancelBits != '0, doneValid};

   // new events win over the clear-on-read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqSt_q <= '0;
         irq_q   <= 1'b0;
      end else begin
         irqSt_q <= (rdIrq ? '0 : irqSt_q) | irqEv;
         irq_q   <= |(((rdIrq ? '0 : irqSt_q) | irqEv) & irqMask_q);
      end
   end

   assign irq = irq_q;

   // ********************************************************************
   // read mux
   // ********************************************************************
   logic [31:0] rdBufCfg, rdElemCfg, rdStatus;
   assign rdBufCfg  = {1'b0, queueSel_q, 14'h0000, startAddr_q};
   assign rdElemCfg = {9'h000, elemBytes, 3'h0, elemWords, 5'h00, dfs_q};
   assign rdStatus  = {10'h000, full_q, put_q, 3'h0, get_q, 2'h0, freeLvl};  // RULE4 RULE5

   assign rdMux = (haddr[7:0] == OFS_TX_BUF_CFG)   ? rdBufCfg  :
                  (haddr[7:0] == OFS_TX_ELEM_CFG)  ? rdElemCfg :
                  (haddr[7:0] == OFS_TX_FQ_STATUS) ? rdStatus  :
                  (haddr[7:0] == OFS_TX_ADD_REQ)   ? pend_q    :
                  (haddr[7:0] == OFS_NEXT_ADDR)    ? {16'h0000, nextFreeAddr} :
                  (haddr[7:0] == OFS_IRQ_STATUS)   ? {29'h0000_0000, irqSt_q} :
                  (haddr[7:0] == OFS_IRQ_MASK)     ? {29'h0000_0000, irqMask_q} : READ_ZERO;

   // ********************************************************************
   // checks
   // ********************************************************************
   a_fifo_done_get: assert property (@(posedge sys_clk) disable iff (rst)
      (!queueSel_q && doneValid && txIdx == get_q) |=> (get_q == $past(get_q) + IDX_W'(1))) // RULE3
      else $error("get index did not advance after transmission");

   a_fifo_put_n: assert property (@(posedge sys_clk) disable iff (rst)
      !queueSel_q |=> (put_q == $past(put_q) + $past(nAdd[IDX_W-1:0])))  // RULE8
      else $error("put index did not advance by number of adds");

   a_full_flag: assert property (@(posedge sys_clk) disable iff (rst)
      (!queueSel_q && full_q) |-> (put_q == get_q && pend_q != '0))  // RULE5
      else $error("full flag set without put equal get");

   a_level_empty: assert property (@(posedge sys_clk) disable iff (rst)
      (pend_q == '0 && !queueSel_q) |-> (freeLvl == LVL_W'(NUM_BUF)))  // RULE4
      else $error("empty fifo does not report all free");

   a_cancel_other: assert property (@(posedge sys_clk) disable iff (rst)
      (!queueSel_q && wrCancel && !hwdata[get_q] && !doneValid && !wrAdd) |=> $stable(get_q) && $stable(freeLvl)) // RULE11
      else $error("cancel of other buffer moved get index");

   a_cancel_get: assert property (@(posedge sys_clk) disable iff (rst)
      (!queueSel_q && cancelAtGet && nextPendFound) |=> (get_q == $past(nextPendIdx)))  // RULE10
      else $error("get index not moved to next pending after cancel");

   a_addr_calc: assert property (@(posedge sys_clk) disable iff (rst)
      nextFreeAddr == startAddr_q + ADDR_W'(put_q * tcq_elem_words(dfs_q)))  // RULE12
      else $error("next free address wrong");

   a_queue_full: assert property (@(posedge sys_clk) disable iff (rst)
      (queueSel_q && &pend_q) |=> (full_q || !(&$past(pend_d))) && (put_q == $past(put_q))) // RULE17
      else $error("full queue moved put index");

   a_queue_put: assert property (@(posedge sys_clk) disable iff (rst)
      (queueSel_q && nAdd != '0 && !(&pend_d)) |=> !pend_q[put_q])  // RULE15
      else $error("queue put index not at a free buffer");

   a_req_follows: assert property (@(posedge sys_clk) disable iff (rst)
      (!txBusy && !txDone && selValid) |=> (txReq && txIdx == $past(selIdx)))  // RULE2 RULE13
      else $error("request does not follow selected buffer");

endmodule : tcq_tx_queue_mgr

// ===== testbench/tcq_eng_model.sv
/* tcq_eng_model: behavioural protocol engine on the far side of the tx manager.
   assumes: one clock; the bench gates new sends with go and sets the send latency. */
`timescale 1ns/10ps
module tcq_eng_model
   import tcq_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             go,
   input  wire logic [3:0]       lat,
   input  wire logic             txReq,
   input  wire logic [IDX_W-1:0] txIdx,
   output logic                  txBusy,
   output logic                  txDone
);
   // ****************
   // send sequencer
   // ****************
   logic [IDX_W-1:0] cur;
   logic [3:0]       cnt;
   logic [1:0]       cool;
   int               sentQ[$];
   // cool-down so a stale txReq just after done is never taken
   always @(posedge sys_clk) begin
      if (rst) begin
         txBusy <= 1'b0;
         txDone <= 1'b0;
         cool   <= 2'h0;
      end else if (txBusy) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h0) begin
            txBusy <= 1'b0;
            txDone <= 1'b1;
            cool   <= 2'h2;
            sentQ.push_back(int'(cur));
         end
      end else if (!txDone && cool == 2'h0 && go && txReq) begin
         txBusy <= 1'b1;
         cur    <= txIdx;
         cnt    <= lat;
      end else begin
         txDone <= 1'b0;
         if (cool != 2'h0) cool <= cool - 2'h1;
      end
   end
endmodule : tcq_eng_model

// ===== testbench/tcq_tx_queue_mgr_tb.sv
/* tcq_tx_queue_mgr_tb: self-checking bench for the tx FIFO / queue manager.
   assumes: zero-wait AHB-Lite slave, engine model drives txBusy and txDone. */
`timescale 1ns/10ps
module tcq_tx_queue_mgr_tb
   import tcq_pkg::*;
   ;
   // ****************
   // harness
   // ****************
   logic             sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic             idWrEn, txBusy, txDone, txReq, go;
   logic [31:0]      haddr, hwdata, hrdata, rd;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic [3:0]       lat;
   logic [IDX_W-1:0] idWrIdx, txIdx;
   logic [ID_W-1:0]  idWrVal;
   int               miscompares, tests_run;
   assign hready = hreadyout;
   tcq_tx_queue_mgr i_dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .idWrEn, .idWrIdx, .idWrVal, .txBusy, .txDone, .txReq, .txIdx, .irq);
   tcq_eng_model i_eng (.sys_clk, .rst, .go, .lat, .txReq, .txIdx, .txBusy, .txDone);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      #100_000;
      miscompares++;
      results();
   end
   task automatic results();
      $display("ran %0d compares, %0d mismatches", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   // single word transfer; the master never assumes a latency
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= TCQ_HTRANS_NONSEQ;
      hwrite <= wr;
      haddr  <= 32'(a);
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= TCQ_HTRANS_IDLE;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic stat(input logic [5:0] lvl, input logic [4:0] g, input logic [4:0] p, input logic f);
      ahb(1'b0, OFS_TX_FQ_STATUS, READ_ZERO);
      chk(rd, {10'h000, f, p, 3'h0, g, 2'h0, lvl}, "fifo status");
      chk(32'(hresp), READ_ZERO, "bus response");
   endtask : stat
   task automatic setId(input logic [4:0] i, input logic [ID_W-1:0] v);
      idWrEn  <= 1'b1;
      idWrIdx <= i;
      idWrVal <= v;
      @(posedge sys_clk);
      idWrEn  <= 1'b0;
      @(posedge sys_clk);
   endtask : setId
   task automatic sendN(input int n, input logic [3:0] l);
      int base;
      base = i_eng.sentQ.size();
      lat <= l;
      go  <= 1'b1;
      while (i_eng.sentQ.size() < base + n) @(posedge sys_clk);
      go  <= 1'b0;
      @(posedge sys_clk);
   endtask : sendN
   // ****************
   // scenarios
   // ****************
   task automatic tSize();
      int w[8] = '{4, 5, 6, 7, 8, 10, 14, 18};
      int b[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
      stat(6'h20, 5'h00, 5'h00, 1'b0);
      ahb(1'b0, OFS_TX_BUF_CFG, READ_ZERO);
      chk(rd, READ_ZERO, "buf cfg reset");
      for (int c = 0; c < 8; c++) begin
         ahb(1'b1, OFS_TX_ELEM_CFG, 32'(c));
         ahb(1'b0, OFS_TX_ELEM_CFG, READ_ZERO);
         chk(rd, {9'h000, 7'(b[c]), 3'h0, 5'(w[c]), 5'h00, 3'(c)}, "elem cfg");
      end
      $display("test size done");
   endtask : tSize
   task automatic tFifo();
      // buffer 2 has the lowest id, so a priority pick would reorder
      setId(5'h00, 29'h0009);
      setId(5'h01, 29'h0009);
      setId(5'h02, 29'h0003);
      setId(5'h03, 29'h0009);
      ahb(1'b1, OFS_TX_BUF_CFG, 32'h0000_0100);
      ahb(1'b1, OFS_TX_ADD_REQ, 32'h0000_0007);
      stat(6'h1D, 5'h00, 5'h03, 1'b0);
      ahb(1'b0, OFS_NEXT_ADDR, READ_ZERO);
      chk(rd, 32'h0000_0136, "next addr");
      chk(32'({txReq, txIdx}), 32'h0000_0020, "first request");
      ahb(1'b1, OFS_TX_ADD_REQ, 32'h0000_0008);
      sendN(4, 4'h3);
      for (int k = 0; k < 4; k++) chk(32'(i_eng.sentQ[k]), 32'(k), "fifo order");
      stat(6'h20, 5'h04, 5'h04, 1'b0);
      i_eng.sentQ.delete();
      $display("test fifo done");
   endtask : tFifo
   task automatic tFull();
      ahb(1'b1, OFS_TX_ADD_REQ, 32'hFFFF_FFFF);
      stat(6'h00, 5'h04, 5'h04, 1'b1);
      sendN(1, 4'h0);
      chk(32'(i_eng.sentQ[0]), 32'h0000_0004, "full send");
      stat(6'h01, 5'h05, 5'h04, 1'b0);
      i_eng.sentQ.delete();
      $display("test full done");
   endtask : tFull
   task automatic tCancel();
      ahb(1'b1, OFS_TX_CANCEL, 32'h0000_0080);
      stat(6'h01, 5'h05, 5'h04, 1'b0);
      ahb(1'b1, OFS_TX_CANCEL, 32'h0000_0020);
      stat(6'h02, 5'h06, 5'h04, 1'b0);
      ahb(1'b1, OFS_TX_CANCEL, 32'h0000_0040);
      stat(6'h04, 5'h08, 5'h04, 1'b0);
      ahb(1'b1, OFS_TX_CANCEL, 32'hFFFF_FFFF);
      stat(6'h20, 5'h04, 5'h04, 1'b0);
      ahb(1'b0, OFS_TX_ADD_REQ, READ_ZERO);
      chk(rd, READ_ZERO, "pending cleared");
      $display("test cancel done");
   endtask : tCancel
   task automatic tQueue();
      int ord[4] = '{5, 6, 7, 4};
      setId(5'h04, 29'h0032);
      setId(5'h05, 29'h0007);
      setId(5'h06, 29'h0007);
      setId(5'h07, 29'h001E);
      ahb(1'b1, OFS_TX_BUF_CFG, 32'h4000_0000);
      ahb(1'b1, OFS_TX_ADD_REQ, 32'h0000_00F0);
      ahb(1'b0, OFS_TX_FQ_STATUS, READ_ZERO);
      chk(rd & 32'h003F_0000, 32'h0008_0000, "queue put");
      sendN(4, 4'h1);
      for (int k = 0; k < 4; k++) chk(32'(i_eng.sentQ[k]), 32'(ord[k]), "queue order");
      ahb(1'b1, OFS_TX_ADD_REQ, 32'hFFFF_FFFF);
      ahb(1'b0, OFS_TX_FQ_STATUS, READ_ZERO);
      chk(rd & 32'h003F_0000, 32'h0028_0000, "queue full");
      ahb(1'b1, OFS_TX_CANCEL, 32'hFFFF_FFFF);
      $display("test queue done");
   endtask : tQueue
   task automatic tIrq();
      ahb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      ahb(1'b0, OFS_IRQ_MASK, READ_ZERO);
      chk(rd, 32'h0000_0001, "mask");
      chk(32'(irq), 32'h0000_0001, "irq unmasked");
      ahb(1'b0, OFS_IRQ_STATUS, READ_ZERO);
      ahb(1'b0, OFS_IRQ_STATUS, READ_ZERO);
      chk(rd, READ_ZERO, "status cleared");
      chk(32'(irq), READ_ZERO, "irq after clear");
      ahb(1'b1, OFS_TX_ADD_REQ, 32'h0000_0100);
      sendN(1, 4'h5);
      repeat (3) @(posedge sys_clk);
      chk(32'(irq), 32'h0000_0001, "irq on done");
      ahb(1'b0, OFS_IRQ_STATUS, READ_ZERO);
      chk(rd, 32'h0000_0001, "done event");
      @(posedge sys_clk);
      chk(32'(irq), READ_ZERO, "irq dropped");
      // cancel event is masked off: status sets, the line stays low
      ahb(1'b1, OFS_TX_ADD_REQ, 32'h0000_0200);
      ahb(1'b1, OFS_TX_CANCEL, 32'h0000_0200);
      repeat (3) @(posedge sys_clk);
      chk(32'(irq), READ_ZERO, "irq masked");
      ahb(1'b0, OFS_IRQ_STATUS, READ_ZERO);
      chk(rd, 32'h0000_0002, "cancel event");
      ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h20, READ_ZERO);
      chk(rd, READ_ZERO, "unmapped");
      $display("test irq done");
   endtask : tIrq
   initial begin
      rst     = 1'b1;
      hsel    = 1'b0;
      haddr   = READ_ZERO;
      htrans  = TCQ_HTRANS_IDLE;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = READ_ZERO;
      idWrEn  = 1'b0;
      idWrIdx = 5'h00;
      idWrVal = 29'h0000;
      go      = 1'b0;
      lat     = 4'h0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      tSize();
      tFifo();
      tFull();
      tCancel();
      tQueue();
      tIrq();
      results();
   end
endmodule : tcq_tx_queue_mgr_tb
